//--- design/cio_pkg.sv
// Purpose: shared constants for the camera i/o line routing block
// Assumes: apb register bus, 32-bit data, one word per register
// Notes: line source and trigger select codes live here as well

// ****************************************************************
// package
// ****************************************************************
package cio_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // line counts
  localparam int N_IN = 2;
  localparam int N_OUT = 4;
  localparam int N_LINES = 6;

  // register byte offsets
  localparam logic [7:0] OFF_TRIG_SRC = 8'h00;
  localparam logic [7:0] OFF_LINE_STATUS_ALL = 8'h04;
  localparam logic [7:0] OFF_LINE_SEL = 8'h08;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LINE_SRC = 8'h10;
  localparam logic [7:0] OFF_USER_OUT = 8'h14;

  // field positions
  localparam int TRIG_FS_LSB = 0;
  localparam int TRIG_AS_LSB = 2;
  localparam int TRIG_MODE_BIT = 8;
  localparam int STAT_OUT_LSB = 4;
  localparam int SRC_W = 3;

  // trigger source select codes
  localparam logic [1:0] TSEL_NONE = 2'h0;
  localparam logic [1:0] TSEL_LINE1 = 2'h1;
  localparam logic [1:0] TSEL_LINE2 = 2'h2;

  // output line source codes
  localparam logic [2:0] SRC_EXPOSURE = 3'h0;
  localparam logic [2:0] SRC_TRIG_READY = 3'h1;
  localparam logic [2:0] SRC_TRIG_WAIT = 3'h2;
  localparam logic [2:0] SRC_USER = 3'h3;
  localparam logic [2:0] SRC_LOW = 3'h4;

  // reset values, per acquisition control mode where they differ
  localparam logic [1:0] RST_FS_STD = 2'h1;
  localparam logic [1:0] RST_AS_STD = 2'h2;
  localparam logic [1:0] RST_FS_LEG = 2'h0;
  localparam logic [1:0] RST_AS_LEG = 2'h1;
  localparam logic [11:0] RST_LINE_SRC = 12'h6c8;
  localparam logic [3:0] RST_USER_OUT = 4'h0;
  localparam logic [2:0] RST_LINE_SEL = 3'h0;

endpackage : cio_pkg

//--- design/cio_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous input pins
// Assumes: inputs are static levels, not pulses shorter than a cycle
// Notes: the first stage is read only by the second stage

`timescale 1ns/1ns

// ****************************************************************
// synchroniser
// ****************************************************************
module cio_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cio_sync_state_t;

  cio_sync_state_t st;
  cio_sync_state_t next_st;

  // shift the pins through two stages
  always_comb begin
    next_st = st;
    next_st.meta = d;
    next_st.stable = st.meta;
  end

  // state frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (pce) begin
      st <= next_st;
    end
  end

  assign q = st.stable;

  // output follows the pin two enabled edges later
  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      $past(pce, 1) && $past(pce, 2) && $past(presetn, 2)
      |-> q == $past(d, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchroniser output does not match pin two cycles ago");

endmodule : cio_sync

//--- design/cio_line_routing.sv
// Purpose: routes the camera's isolated input and output lines
// Assumes: apb slave at pclk, internal camera signals on pclk
// Notes: zero wait state bus; mode strap taken once after reset

`timescale 1ns/1ns

// ****************************************************************
// line routing top
// ****************************************************************
module cio_line_routing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cio_pkg::ADDR_W-1:0] paddr,
  input wire logic [cio_pkg::DATA_W-1:0] pwdata,
  output logic [cio_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic legacy_mode_strap,
  input wire logic [cio_pkg::N_IN-1:0] in_line_pin,
  input wire logic exposure_active_out,
  input wire logic trigger_ready_out,
  input wire logic acq_trigger_wait,
  output logic external_trigger_in_frame,
  output logic external_trigger_in_acq,
  output logic [cio_pkg::N_IN-1:0] user_in,
  output logic [cio_pkg::N_OUT-1:0] out_line
);

  typedef struct packed {
    logic init_done;
    logic legacy;
    logic [1:0] fs_src;
    logic [1:0] as_src;
    logic [2:0] line_sel;
    logic [11:0] line_src;
    logic [3:0] user_out;
    logic [cio_pkg::N_OUT-1:0] out_line;
    logic trig_fs;
    logic trig_as;
    logic [cio_pkg::N_IN-1:0] user_in;
    logic [cio_pkg::DATA_W-1:0] prdata;
  } cio_state_t;

  cio_state_t st;
  cio_state_t next_st;
  logic [cio_pkg::N_IN-1:0] in_sync;
  logic [cio_pkg::N_IN-1:0] in_taken;
  logic [cio_pkg::N_OUT-1:0] out_level;
  logic [cio_pkg::N_LINES-1:0] all_lines;
  logic addr_ok;
  logic wr_take;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // pins are asynchronous to pclk, so nothing reads them raw
  cio_sync #(
    .WIDTH(cio_pkg::N_IN)
  ) u_in_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .d(in_line_pin),
    .q(in_sync)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one-of-two pick: a select code never ors lines together
  function automatic logic pick_line(input logic [1:0] sel,
                                     input logic [1:0] lines);
    case (sel)
      cio_pkg::TSEL_LINE1: pick_line = lines[0];
      cio_pkg::TSEL_LINE2: pick_line = lines[1];
      default: pick_line = 1'b0;
    endcase
  endfunction : pick_line

  // output source mux; trigger wait exists only in standard mode
  // internal levels are arguments so the assign wakes when they move
  function automatic logic pick_src(input logic [2:0] code,
                                    input logic legacy,
                                    input logic user,
                                    input logic expo,
                                    input logic ready,
                                    input logic waiting);
    case (code)
      cio_pkg::SRC_EXPOSURE: pick_src = expo;
      cio_pkg::SRC_TRIG_READY: pick_src = ready;
      cio_pkg::SRC_TRIG_WAIT: pick_src = waiting && !legacy;
      cio_pkg::SRC_USER: pick_src = user;
      default: pick_src = 1'b0;
    endcase
  endfunction : pick_src

  // ****************************************************************
  // per line routing
  // ****************************************************************
  // a line is taken when the acquisition trigger selects it, or the frame trigger does outside legacy mode
  for (genvar i = 0; i < cio_pkg::N_IN; i++) begin : g_in
    assign in_taken[i] = (st.as_src == 2'(i + 1))
      || (!st.legacy && st.fs_src == 2'(i + 1));
  end

  // each output line picks from its own source field
  for (genvar j = 0; j < cio_pkg::N_OUT; j++) begin : g_out
    assign out_level[j] = pick_src(
      st.line_src[j*cio_pkg::SRC_W +: cio_pkg::SRC_W],
      st.legacy, st.user_out[j], exposure_active_out,
      trigger_ready_out, acq_trigger_wait);
  end

  assign all_lines = {st.out_line, in_sync};

  // ****************************************************************
  // bus decode
  // ****************************************************************
  always_comb begin
    case (paddr)
      cio_pkg::OFF_TRIG_SRC,
      cio_pkg::OFF_LINE_STATUS_ALL,
      cio_pkg::OFF_LINE_SEL,
      cio_pkg::OFF_LINE_STATUS,
      cio_pkg::OFF_LINE_SRC,
      cio_pkg::OFF_USER_OUT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // no wait states, but a frozen block cannot complete a transfer
  assign pready = psel && penable && pce;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_take = psel && penable && pwrite && addr_ok;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // routed trigger and user input levels
    next_st.trig_fs = st.legacy ? 1'b0
      : pick_line(st.fs_src, in_sync);
    next_st.trig_as = pick_line(st.as_src, in_sync);
    next_st.user_in = in_sync & ~in_taken;
    // logic one means the transistor conducts
    next_st.out_line = out_level;

    // read data captured in the setup phase, held through access
    if (psel && !penable) begin
      next_st.prdata = '0;
      case (paddr)
        cio_pkg::OFF_TRIG_SRC: begin
          next_st.prdata[cio_pkg::TRIG_FS_LSB +: 2] = st.fs_src;
          next_st.prdata[cio_pkg::TRIG_AS_LSB +: 2] = st.as_src;
          next_st.prdata[cio_pkg::TRIG_MODE_BIT] = st.legacy;
        end
        cio_pkg::OFF_LINE_STATUS_ALL: begin
          next_st.prdata[cio_pkg::N_IN-1:0] = in_sync;
          next_st.prdata[cio_pkg::STAT_OUT_LSB +: cio_pkg::N_OUT] =
            st.out_line;
        end
        cio_pkg::OFF_LINE_SEL: next_st.prdata[2:0] = st.line_sel;
        cio_pkg::OFF_LINE_STATUS: begin
          // selectors past the last line read as zero
          next_st.prdata[0] = (st.line_sel < 3'(cio_pkg::N_LINES))
            ? all_lines[st.line_sel] : 1'b0;
        end
        cio_pkg::OFF_LINE_SRC: next_st.prdata[11:0] = st.line_src;
        cio_pkg::OFF_USER_OUT: next_st.prdata[3:0] = st.user_out;
        default: next_st.prdata = '0;
      endcase
    end

    // register writes land at the access edge; status is read only
    if (wr_take) begin
      case (paddr)
        cio_pkg::OFF_TRIG_SRC: begin
          next_st.fs_src = pwdata[cio_pkg::TRIG_FS_LSB +: 2];
          next_st.as_src = pwdata[cio_pkg::TRIG_AS_LSB +: 2];
        end
        cio_pkg::OFF_LINE_SEL: next_st.line_sel = pwdata[2:0];
        cio_pkg::OFF_LINE_SRC: next_st.line_src = pwdata[11:0];
        cio_pkg::OFF_USER_OUT: next_st.user_out = pwdata[3:0];
        default: next_st = next_st;
      endcase
    end

    // first enabled edge after reset: take the strap and load the
    // mode dependent defaults; this wins over a write in that cycle
    if (!st.init_done) begin
      next_st.init_done = 1'b1;
      next_st.legacy = legacy_mode_strap;
      next_st.fs_src = legacy_mode_strap ? cio_pkg::RST_FS_LEG
        : cio_pkg::RST_FS_STD;
      next_st.as_src = legacy_mode_strap ? cio_pkg::RST_AS_LEG
        : cio_pkg::RST_AS_STD;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fs_src <= cio_pkg::RST_FS_STD;
      st.as_src <= cio_pkg::RST_AS_STD;
      st.line_sel <= cio_pkg::RST_LINE_SEL;
      st.line_src <= cio_pkg::RST_LINE_SRC;
      st.user_out <= cio_pkg::RST_USER_OUT;
    end else if (pce) begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign external_trigger_in_frame = st.trig_fs;
  assign external_trigger_in_acq = st.trig_as;
  assign user_in = st.user_in;
  assign out_line = st.out_line;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_std_defaults;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.init_done) && !st.legacy
      |-> st.fs_src == cio_pkg::TSEL_LINE1
       && st.as_src == cio_pkg::TSEL_LINE2;
  endproperty
  a_std_defaults: assert property (p_std_defaults)
    else $error("standard mode trigger defaults wrong after reset");

  property p_leg_defaults;
    @(posedge pclk) disable iff (!presetn)
      $rose(st.init_done) && st.legacy
      |-> st.as_src == cio_pkg::TSEL_LINE1;
  endproperty
  a_leg_defaults: assert property (p_leg_defaults)
    else $error("legacy mode trigger default wrong after reset");

  property p_trig_route;
    @(posedge pclk) disable iff (!presetn)
      $past(pce) && $past(st.as_src) == cio_pkg::TSEL_LINE2
      |-> external_trigger_in_acq == $past(in_sync[1]);
  endproperty
  a_trig_route: assert property (p_trig_route)
    else $error("acquisition trigger does not follow input line 2");

  property p_taken_masked;
    @(posedge pclk) disable iff (!presetn)
      $past(pce) && $past(in_taken[0]) |-> !user_in[0];
  endproperty
  a_taken_masked: assert property (p_taken_masked)
    else $error("trigger line leaks onto user input");

  property p_free_passes;
    @(posedge pclk) disable iff (!presetn)
      $past(pce) && !$past(in_taken[1])
      |-> user_in[1] == $past(in_sync[1]);
  endproperty
  a_free_passes: assert property (p_free_passes)
    else $error("unassigned input line not passed to user input");

  property p_status_all;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && pce
      && paddr == cio_pkg::OFF_LINE_STATUS_ALL
      ##1 psel && penable
      |-> prdata[1:0] == $past(in_sync);
  endproperty
  a_status_all: assert property (p_status_all)
    else $error("combined line status read does not show inputs");

  property p_out1_exposure;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) && $past(pce)
      && $past(st.line_src[2:0]) == cio_pkg::SRC_EXPOSURE
      |-> out_line[0] == $past(exposure_active_out);
  endproperty
  a_out1_exposure: assert property (p_out1_exposure)
    else $error("output 1 does not follow exposure active");

  property p_out2_ready;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) && $past(pce)
      && $past(st.line_src[5:3]) == cio_pkg::SRC_TRIG_READY
      |-> out_line[1] == $past(trigger_ready_out);
  endproperty
  a_out2_ready: assert property (p_out2_ready)
    else $error("output 2 does not follow trigger ready");

  property p_src_write;
    @(posedge pclk) disable iff (!presetn)
      pce && wr_take && st.init_done && paddr == cio_pkg::OFF_LINE_SRC
      |=> st.line_src == $past(pwdata[11:0]);
  endproperty
  a_src_write: assert property (p_src_write)
    else $error("line source write not taken");

  property p_low_src;
    @(posedge pclk) disable iff (!presetn)
      $past(pce) && $past(st.line_src[11:9]) == cio_pkg::SRC_LOW
      |-> !out_line[3];
  endproperty
  a_low_src: assert property (p_low_src)
    else $error("output 4 conducts while its source is low");

endmodule : cio_line_routing

//--- testbench/cio_partner.sv
// Purpose: far side of the line routing block: trigger sources, monitors
// Assumes: pins are driven asynchronously to the core clock
// Notes: monitor shows the conducting state of each output line

`timescale 1ns/1ns

// ****************************************************************
// partner model
// ****************************************************************
module cio_partner (
  input wire logic [1:0] drive_level,
  input wire logic [3:0] out_line,
  output logic [1:0] in_line_pin,
  output logic [3:0] lit
);
  // skewed off the clock so the synchroniser sees a true async edge
  assign #7 in_line_pin = drive_level;
  // a conducting output lights its monitor, one per line
  assign lit = out_line;
endmodule : cio_partner

//--- testbench/testbench.sv
// Purpose: self-checking bench for the camera i/o line routing block
// Assumes: zero wait apb slave, pce low only in the freeze scenario
// Notes: read results are queued by the driver and checked by a monitor

`timescale 1ns/1ns

// ****************************************************************
// bench top
// ****************************************************************
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [cio_pkg::ADDR_W-1:0] paddr = '0;
  logic [cio_pkg::DATA_W-1:0] pwdata = '0;
  logic [cio_pkg::DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic legacy_mode_strap = 1'b0;
  logic [1:0] pin_req = 2'h0;
  logic [1:0] in_line_pin;
  logic exposure_active_out = 1'b0;
  logic trigger_ready_out = 1'b0;
  logic acq_trigger_wait = 1'b0;
  logic ext_fs;
  logic ext_as;
  logic [1:0] user_in;
  logic [3:0] out_line;
  logic [3:0] lit;
  logic [11:0] src;
  logic [3:0] uo;
  logic leg;
  logic [7:0] hold_exp;
  logic [32:0] exp_q[$];
  int fails = 0;
  int checked = 0;

  always #25 pclk = ~pclk;

  cio_line_routing DUT (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .legacy_mode_strap(legacy_mode_strap), .in_line_pin(in_line_pin),
    .exposure_active_out(exposure_active_out),
    .trigger_ready_out(trigger_ready_out),
    .acq_trigger_wait(acq_trigger_wait),
    .external_trigger_in_frame(ext_fs), .external_trigger_in_acq(ext_as),
    .user_in(user_in), .out_line(out_line));

  cio_partner far_side (.drive_level(pin_req), .out_line(out_line),
    .in_line_pin(in_line_pin), .lit(lit));

  // ****************************************************************
  // compare and closing tasks
  // ****************************************************************
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] e);
    checked++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_rd

  task automatic cmp_line(input logic [7:0] got, input logic [7:0] e);
    checked++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_line

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // apb master and models of expected line behaviour
  // ****************************************************************
  // idle edge at the end so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  // returns {user_in, acq, frame}; legacy leaves the frame path dead
  function automatic logic [3:0] route(input logic [1:0] fs,
                                       input logic [1:0] as);
    logic fr;
    logic ac;
    logic [1:0] u;
    fr = (fs == cio_pkg::TSEL_LINE1) ? pin_req[0] :
         (fs == cio_pkg::TSEL_LINE2) ? pin_req[1] : 1'b0;
    ac = (as == cio_pkg::TSEL_LINE1) ? pin_req[0] :
         (as == cio_pkg::TSEL_LINE2) ? pin_req[1] : 1'b0;
    u = pin_req;
    if (as == cio_pkg::TSEL_LINE1 || (!leg && fs == cio_pkg::TSEL_LINE1))
      u[0] = 1'b0;
    if (as == cio_pkg::TSEL_LINE2 || (!leg && fs == cio_pkg::TSEL_LINE2))
      u[1] = 1'b0;
    return {u, ac, fr & ~leg};
  endfunction : route

  function automatic logic [3:0] out_exp();
    logic [3:0] o;
    for (int i = 0; i < 4; i++) begin
      case (src[3*i +: 3])
        cio_pkg::SRC_EXPOSURE: o[i] = exposure_active_out;
        cio_pkg::SRC_TRIG_READY: o[i] = trigger_ready_out;
        cio_pkg::SRC_TRIG_WAIT: o[i] = acq_trigger_wait & ~leg;
        cio_pkg::SRC_USER: o[i] = uo[i];
        default: o[i] = 1'b0;
      endcase
    end
    return o;
  endfunction : out_exp

  // fresh pins and internal levels, then wait out the sync latency
  task automatic check_lines(input logic [1:0] fs, input logic [1:0] as);
    pin_req <= 2'($urandom);
    exposure_active_out <= 1'($urandom);
    trigger_ready_out <= 1'($urandom);
    acq_trigger_wait <= 1'($urandom);
    repeat (5) @(posedge pclk);
    cmp_line({4'h0, user_in, ext_as, ext_fs}, {4'h0, route(fs, as)});
    cmp_line({4'h0, lit}, {4'h0, out_exp()});
    rd(cio_pkg::OFF_LINE_STATUS_ALL, {25'h0, out_exp(), 2'h0, pin_req});
  endtask : check_lines

  task automatic do_reset(input logic l);
    presetn <= 1'b0;
    legacy_mode_strap <= l;
    leg = l;
    src = cio_pkg::RST_LINE_SRC;
    uo = cio_pkg::RST_USER_OUT;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  // monitor: every completed read is matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) fails++;
      else cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    void'($urandom(32'h75a9));
    do_reset(1'b0);
    rd(cio_pkg::OFF_TRIG_SRC, 33'h9);
    rd(cio_pkg::OFF_LINE_SRC, 33'h6c8);
    rd(cio_pkg::OFF_USER_OUT, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    check_lines(cio_pkg::RST_FS_STD, cio_pkg::RST_AS_STD);
    // every pairing of trigger selections, sharing one line excluded
    for (int k = 0; k < 16; k++) begin
      if (k[1:0] == k[3:2] && k[1:0] != 2'h0 && k[1:0] != 2'h3) continue;
      wr(cio_pkg::OFF_TRIG_SRC, 32'(k));
      rd(cio_pkg::OFF_TRIG_SRC, 33'(k));
      check_lines(k[1:0], k[3:2]);
    end
    wr(cio_pkg::OFF_TRIG_SRC, 32'h9);
    for (int k = 0; k < 8; k++) begin
      src = 12'($urandom);
      uo = 4'($urandom);
      wr(cio_pkg::OFF_LINE_SRC, 32'(src));
      wr(cio_pkg::OFF_USER_OUT, 32'(uo));
      rd(cio_pkg::OFF_LINE_SRC, 33'(src));
      check_lines(2'h1, 2'h2);
    end
    for (int s = 0; s < 8; s++) begin
      wr(cio_pkg::OFF_LINE_SEL, 32'(s));
      rd(cio_pkg::OFF_LINE_SEL, 33'(s));
      rd(cio_pkg::OFF_LINE_STATUS, 33'((s < 6) ? (({out_exp(), pin_req} >> s) & 1) : 0));
    end
    // frozen block: pins and levels move, outputs must hold
    hold_exp = {route(2'h1, 2'h2), out_exp()};
    pce <= 1'b0;
    pin_req <= ~pin_req;
    exposure_active_out <= ~exposure_active_out;
    trigger_ready_out <= ~trigger_ready_out;
    repeat (6) @(posedge pclk);
    cmp_line({user_in, ext_as, ext_fs, lit}, hold_exp);
    pce <= 1'b1;
    check_lines(2'h1, 2'h2);
    do_reset(1'b1);
    rd(cio_pkg::OFF_TRIG_SRC, 33'h104);
    check_lines(cio_pkg::RST_FS_LEG, cio_pkg::RST_AS_LEG);
    src = 12'h492;
    wr(cio_pkg::OFF_LINE_SRC, 32'(src));
    check_lines(cio_pkg::RST_FS_LEG, cio_pkg::RST_AS_LEG);
    conclude();
  end

  initial begin
    #(50 * 20000);
    fails++;
    conclude();
  end
endmodule : testbench
